/* File: hdl/ucw_pkg.sv */
// Package: register map, field positions and constants for the config decoder
package ucw_pkg;

   // Register byte addresses on the AHB-Lite slave
   localparam logic [7:0]  UCW_OFS_WORD0    = 8'h00;
   localparam logic [7:0]  UCW_OFS_WORD1    = 8'h04;
   localparam logic [7:0]  UCW_OFS_STATUS   = 8'h08;
   localparam logic [7:0]  UCW_OFS_CTRL     = 8'h0C;
   localparam logic [7:0]  UCW_OFS_DECODE   = 8'h10;

   // Field positions in word 0
   localparam int UCW_POS_WDT_MSB   = 31;
   localparam int UCW_POS_BOV_HI    = 22;
   localparam int UCW_POS_BOV_LO    = 21;
   localparam int UCW_POS_BORST     = 20;
   localparam int UCW_POS_DEBUG     = 12;
   localparam int UCW_POS_IOINI     = 10;
   localparam int UCW_POS_BOOT_HI   = 7;
   localparam int UCW_POS_BOOT_LO   = 6;
   localparam int UCW_POS_MASS_ERASE = 5;
   localparam int UCW_POS_WDT_HI    = 4;
   localparam int UCW_POS_WDT_LO    = 3;
   localparam int UCW_POS_LOCK      = 1;
   localparam int UCW_POS_DATA_EN   = 0;

   // Used bits of word 0; everything else is reserved and masked
   localparam logic [31:0] UCW_WORD0_MASK   = 32'h807014FB;
   // Word 1 keeps only the data region base
   localparam logic [31:0] UCW_WORD1_MASK   = 32'h000FFFFF;
   localparam int          UCW_DATA_BASE_W  = 20;

   // Threshold in millivolts per brown-out code
   localparam logic [12:0] UCW_BOV_MV_00    = 13'h0898;  // 2200
   localparam logic [12:0] UCW_BOV_MV_01    = 13'h0A8C;  // 2700
   localparam logic [12:0] UCW_BOV_MV_10    = 13'h0E74;  // 3700
   localparam logic [12:0] UCW_BOV_MV_11    = 13'h1194;  // 4500

   // Region bases
   localparam logic [31:0] UCW_LOADER_BASE_INAPP = 32'h00100000;
   localparam logic [31:0] UCW_APP_BASE_INAPP    = 32'h00000000;
   localparam logic [31:0] UCW_ZERO_BASE       = 32'h00000000;
   localparam logic [31:0] UCW_LOCKED_READ     = 32'hFFFFFFFF;

   // Reset value of decoded config before load: safest settings
   localparam logic [31:0] UCW_WORD_RESET   = 32'h00000000;
   localparam logic [31:0] UCW_RD_ZERO      = 32'h00000000;

   // Fetch timing
   localparam int UCW_FETCH_NS      = 40;
   localparam int UCW_CLK_NS        = 8;
   localparam int UCW_FETCH_CYC     = (UCW_FETCH_NS + UCW_CLK_NS - 1) /
                                      UCW_CLK_NS;

   typedef enum logic [1:0] {
      UCW_BOOT_LDR_INAPP = 2'h0,
      UCW_BOOT_LDR_ONLY  = 2'h1,
      UCW_BOOT_APP_INAPP = 2'h2,
      UCW_BOOT_APP_ONLY  = 2'h3
   } ucw_boot_type;

endpackage : ucw_pkg

/* File: hdl/ucw_word_fetch.sv */
// Word fetcher: reads one flash config word with a fixed access time
`timescale 1ns/1ps
`default_nettype none
module ucw_word_fetch
   import ucw_pkg::*;
#(
   parameter int WAIT_CYC = UCW_FETCH_CYC
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        start,
   input  wire logic [31:0] flash_data,
   input  wire logic [31:0] mask,
   output logic             done,
   output logic [31:0]      word
);

   typedef struct packed {
      logic [7:0]  count;
      logic        busy;
      logic        done;
      logic [31:0] word;
   } ucw_fetch_state_type;

   ucw_fetch_state_type state;
   ucw_fetch_state_type next_state;

   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (start && !state.busy) begin
         next_state.busy = 1'b1;
         next_state.count = 8'(WAIT_CYC);
      end else if (state.busy) begin
         if (state.count <= 8'h01) begin
            next_state.busy = 1'b0;
            next_state.done = 1'b1;
            // Reserved bits cleared so they never reach a decode
            next_state.word = flash_data & mask;
         end else begin
            next_state.count = state.count - 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign done = state.done;
   assign word = state.word;

endmodule : ucw_word_fetch
`default_nettype wire

/* File: hdl/ucw_config_decode.sv */
// Top: loads user config words after reset and decodes the settings
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ucw_config_decode
   import ucw_pkg::*;
#(
   parameter int WAIT_CYC = UCW_FETCH_CYC
) (
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Flash read port for the config words
   output logic             flash_rd,
   output logic             flash_word_sel,
   input  wire logic [31:0] flash_data,
   // Strap-like inputs from the rest of the chip
   input  wire logic        boot_mode_source_sel,
   input  wire logic [1:0]  default_boot_sel,
   input  wire logic        prog_boot_select,
   input  wire logic        vector_page_map_req,
   input  wire logic        access_trusted,
   input  wire logic [31:0] flash_read_raw,
   // Decoded settings
   output logic             config_valid,
   output logic             cpu_release,
   output logic [1:0]       brownout_level_sel,
   output logic [12:0]      brownout_mv,
   output logic             brownout_reset_en,
   output logic             debug_port_enable,
   output logic             io_quasi_bidir,
   output logic [1:0]       boot_source_sel,
   output logic             boot_from_loader,
   output logic             in_app_programming,
   output logic [31:0]      loader_region_base,
   output logic [31:0]      application_region_base,
   output logic             prog_boot_select_eff,
   output logic             vector_page_map_en,
   output logic [2:0]       watchdog_hw_enable,
   output logic             mass_erase_enable,
   output logic             flash_locked,
   output logic [31:0]      flash_read_data,
   output logic             data_region_enable,
   output logic [19:0]      data_region_base,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);

   typedef enum {
      UCW_ST_IDLE,
      UCW_ST_WORD0,
      UCW_ST_WORD1,
      UCW_ST_DONE
   } ucw_load_type;

   typedef struct packed {
      ucw_load_type load;
      logic         fetch_start;
      logic         loaded;
      logic [31:0]  word0;
      logic [31:0]  word1;
      logic         force_tri;
      logic         dph_valid;
      logic         dph_write;
      logic [7:0]   dph_addr;
      logic [31:0]  rdata;
   } ucw_state_type;

   ucw_state_type state;
   ucw_state_type next_state;

   logic        fetch_done;
   logic [31:0] fetch_word;
   logic        boot_honoured;
   logic [1:0]  boot_eff;

   ucw_word_fetch #(
      .WAIT_CYC (WAIT_CYC)
   ) u_fetch (
      .clock      (clock),
      .reset_n    (reset_n),
      .start      (state.fetch_start),
      .flash_data (flash_data),
      .mask       (state.load == UCW_ST_WORD1 ? UCW_WORD1_MASK
                                              : UCW_WORD0_MASK),
      .done       (fetch_done),
      .word       (fetch_word)
   );

   always_comb begin
      next_state = state;
      next_state.fetch_start = 1'b0;
      // Load sequence runs once per reset
      case (state.load)
         UCW_ST_IDLE: begin
            next_state.fetch_start = 1'b1;
            next_state.load = UCW_ST_WORD0;
         end
         UCW_ST_WORD0: begin
            if (fetch_done) begin
               next_state.word0 = fetch_word;
               next_state.fetch_start = 1'b1;
               next_state.load = UCW_ST_WORD1;
            end
         end
         UCW_ST_WORD1: begin
            if (fetch_done) begin
               next_state.word1 = fetch_word;
               next_state.loaded = 1'b1;
               next_state.load = UCW_ST_DONE;
            end
         end
         UCW_ST_DONE: begin
            next_state.load = UCW_ST_DONE;
         end
         default: begin
            next_state.load = UCW_ST_IDLE;
         end
      endcase

      // AHB-Lite address phase capture
      if (hready) begin
         next_state.dph_valid = hsel && htrans[1];
         next_state.dph_write = hwrite;
         next_state.dph_addr  = haddr;
         next_state.rdata     = UCW_RD_ZERO;
         if (hsel && htrans[1] && !hwrite) begin
            case (haddr)
               UCW_OFS_WORD0:  next_state.rdata = state.word0;
               UCW_OFS_WORD1:  next_state.rdata = state.word1;
               UCW_OFS_STATUS: next_state.rdata =
                  {30'h0, state.force_tri, state.loaded};
               UCW_OFS_CTRL:   next_state.rdata = {31'h0, state.force_tri};
               UCW_OFS_DECODE: next_state.rdata =
                  {18'h0, watchdog_hw_enable, boot_eff, boot_from_loader,
                   in_app_programming, flash_locked, data_region_enable,
                   debug_port_enable, brownout_reset_en, io_quasi_bidir,
                   brownout_level_sel};
               default:        next_state.rdata = UCW_RD_ZERO;
            endcase
         end
      end
      // Write data phase: only the control register is writable
      if (state.dph_valid && state.dph_write &&
          state.dph_addr == UCW_OFS_CTRL) begin
         next_state.force_tri = hwdata[0];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= '{load: UCW_ST_IDLE, word0: UCW_WORD_RESET,
                    word1: UCW_WORD_RESET, default: '0};
      end else begin
         state <= next_state;
      end
   end

   // Flash read strobes
   assign flash_rd       = state.fetch_start;
   assign flash_word_sel = (state.load == UCW_ST_WORD1);

   // Processor held until both words are in
   assign config_valid = state.loaded;
   assign cpu_release  = state.loaded;

   // Brown-out
   assign brownout_level_sel = state.word0[UCW_POS_BOV_HI:UCW_POS_BOV_LO];
   always_comb begin
      case (brownout_level_sel)
         2'h0:    brownout_mv = UCW_BOV_MV_00;
         2'h1:    brownout_mv = UCW_BOV_MV_01;
         2'h2:    brownout_mv = UCW_BOV_MV_10;
         default: brownout_mv = UCW_BOV_MV_11;
      endcase
   end
   assign brownout_reset_en = !state.word0[UCW_POS_BORST];

   assign debug_port_enable = state.word0[UCW_POS_DEBUG];
   // Software may force tri-state start for safe bring-up
   assign io_quasi_bidir = state.word0[UCW_POS_IOINI] &&
                           !state.force_tri;

   // Boot selection
   assign boot_source_sel = state.word0[UCW_POS_BOOT_HI:UCW_POS_BOOT_LO];
   assign boot_honoured   = boot_mode_source_sel;
   assign boot_eff = boot_honoured ? boot_source_sel
                                   : default_boot_sel;
   assign boot_from_loader   = !boot_eff[1];
   assign in_app_programming = !boot_eff[0];
   assign loader_region_base = in_app_programming ? UCW_LOADER_BASE_INAPP
                                                  : UCW_ZERO_BASE;
   assign application_region_base = in_app_programming
                                    ? UCW_APP_BASE_INAPP
                                    : UCW_ZERO_BASE;
   assign prog_boot_select_eff = prog_boot_select && boot_eff[0];
   assign vector_page_map_en = vector_page_map_req && !boot_eff[0];

   assign watchdog_hw_enable = {state.word0[UCW_POS_WDT_MSB],
      state.word0[UCW_POS_WDT_HI:UCW_POS_WDT_LO]};
   assign mass_erase_enable = state.word0[UCW_POS_MASS_ERASE];

   // Lock: untrusted paths see all ones
   assign flash_locked = !state.word0[UCW_POS_LOCK];
   assign flash_read_data = (flash_locked && !access_trusted)
                            ? UCW_LOCKED_READ : flash_read_raw;

   // Base alignment is the programmer's duty and is not corrected here
   assign data_region_enable = !state.word0[UCW_POS_DATA_EN];
   assign data_region_base = state.word1[UCW_DATA_BASE_W-1:0];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = state.rdata;

   property p_bov_code;
      @(posedge clock) disable iff (!reset_n)
      brownout_level_sel == 2'h0 |-> brownout_mv == 13'h0898;
   endproperty
   a_bov_code: assert property (p_bov_code)
      else $error("brown-out code 00 not 2.2V");

   property p_bov_high;
      @(posedge clock) disable iff (!reset_n)
      brownout_level_sel == 2'h3 |-> brownout_mv == 13'h1194;
   endproperty
   a_bov_high: assert property (p_bov_high)
      else $error("brown-out code 11 not 4.5V");

   property p_borst;
      @(posedge clock) disable iff (!reset_n)
      brownout_reset_en != state.word0[20];
   endproperty
   a_borst: assert property (p_borst)
      else $error("brown-out reset polarity wrong");

   property p_debug;
      @(posedge clock) disable iff (!reset_n)
      !state.word0[12] |-> !debug_port_enable;
   endproperty
   a_debug: assert property (p_debug)
      else $error("debug enabled while bit 12 low");

   property p_ioini;
      @(posedge clock) disable iff (!reset_n)
      !state.word0[10] |-> !io_quasi_bidir;
   endproperty
   a_ioini: assert property (p_ioini)
      else $error("pins not tri-state");

   property p_boot;
      @(posedge clock) disable iff (!reset_n)
      boot_mode_source_sel |-> boot_from_loader == !state.word0[7] &&
         in_app_programming == !state.word0[6];
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot decode wrong");

   property p_map;
      @(posedge clock) disable iff (!reset_n)
      !boot_eff[0] |-> loader_region_base == 32'h00100000;
   endproperty
   a_map: assert property (p_map)
      else $error("loader base not remapped");

   property p_bsel;
      @(posedge clock) disable iff (!reset_n)
      !boot_eff[0] |-> !prog_boot_select_eff;
   endproperty
   a_bsel: assert property (p_bsel)
      else $error("boot select active with bit0 low");

   property p_vmap;
      @(posedge clock) disable iff (!reset_n)
      boot_eff[0] |-> !vector_page_map_en;
   endproperty
   a_vmap: assert property (p_vmap)
      else $error("vector map active with bit0 high");

   property p_wdt;
      @(posedge clock) disable iff (!reset_n)
      watchdog_hw_enable[2] == state.word0[31];
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog msb wrong");

   property p_lock;
      @(posedge clock) disable iff (!reset_n)
      flash_locked && !access_trusted |-> flash_read_data == 32'hFFFFFFFF;
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked read not all ones");

   property p_load_once;
      @(posedge clock) disable iff (!reset_n)
      config_valid |=> config_valid && $stable(state.word0);
   endproperty
   a_load_once: assert property (p_load_once)
      else $error("config word changed after load");

endmodule : ucw_config_decode
`default_nettype wire

/* File: test/ucw_flash_model.sv */
// Flash model: serves the two user config words to the loader
`timescale 1ns/1ps
`default_nettype none
module ucw_flash_model #(
   parameter int WAIT_CYC = 3
) (
   input  wire logic        clock,
   input  wire logic        flash_rd,
   input  wire logic        flash_word_sel,
   input  wire logic [31:0] word0,
   input  wire logic [31:0] word1,
   output logic [31:0]      flash_data
);
   int          hold;
   logic        sel;
   logic [31:0] cur;

   initial begin
      hold = 0;
      sel = 1'b0;
   end

   assign cur = sel ? word1 : word0;
   // Not held outside the access window, so show the inverse
   assign flash_data = (hold > 0) ? cur : ~cur;

   always @(posedge clock) begin
      if (flash_rd === 1'b1) begin
         hold <= WAIT_CYC + 2;
         sel  <= flash_word_sel;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end
   end
endmodule : ucw_flash_model
`default_nettype wire

/* File: test/tb_top.sv */
// Testbench: reloads random config words and checks the decoded settings
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int WC = 3;
   logic        clock, reset_n, hsel, hwrite;
   logic        boot_mode_source_sel, prog_boot_select;
   logic        vector_page_map_req, access_trusted;
   logic [1:0]  default_boot_sel, htrans, be;
   logic [2:0]  hsize;
   logic [7:0]  haddr;
   logic [31:0] flash_read_raw, hwdata, w0, w1, lw0, lw1, q, r;
   logic        flash_rd, flash_word_sel, config_valid, cpu_release;
   logic        brownout_reset_en, debug_port_enable, io_quasi_bidir;
   logic        boot_from_loader, in_app_programming, prog_boot_select_eff;
   logic        vector_page_map_en, mass_erase_enable, flash_locked;
   logic        data_region_enable, hreadyout, hresp;
   logic [1:0]  brownout_level_sel, boot_source_sel;
   logic [2:0]  watchdog_hw_enable;
   logic [12:0] brownout_mv;
   logic [19:0] data_region_base;
   logic [31:0] loader_region_base, application_region_base;
   logic [31:0] flash_read_data, hrdata, flash_data;
   // Thresholds in mV: 2.2, 2.7, 3.7, 4.5 V
   logic [12:0] mv_tab [4] = '{13'h0898, 13'h0A8C, 13'h0E74, 13'h1194};
   int          fail_count, samples_checked, rd_pulses, it;
   integer      seed;

   ucw_flash_model #(.WAIT_CYC(WC)) flash (.clock, .flash_rd,
      .flash_word_sel, .word0(w0), .word1(w1), .flash_data);

   ucw_config_decode #(.WAIT_CYC(WC)) uut (.clock, .reset_n, .flash_rd,
      .flash_word_sel, .flash_data, .boot_mode_source_sel,
      .default_boot_sel, .prog_boot_select, .vector_page_map_req,
      .access_trusted, .flash_read_raw, .config_valid, .cpu_release,
      .brownout_level_sel, .brownout_mv, .brownout_reset_en,
      .debug_port_enable, .io_quasi_bidir, .boot_source_sel,
      .boot_from_loader, .in_app_programming, .loader_region_base,
      .application_region_base, .prog_boot_select_eff,
      .vector_page_map_en, .watchdog_hw_enable, .mass_erase_enable,
      .flash_locked, .flash_read_data, .data_region_enable,
      .data_region_base, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      if (reset_n === 1'b1 && flash_rd === 1'b1) begin
         rd_pulses++;
      end
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic give_up(input string nm);
      fail_count++;
      $display("[ERR] %s expected done seen timeout", nm);
      stop_test;
   endtask : give_up

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (n > 50) give_up("hreadyout");
      end while (hreadyout !== 1'b1);
   endtask : wait_rdy

   // One single word transfer; read data taken at the data phase's end
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask : ahb

   task automatic check_out(input logic ft);
      logic [1:0] eff;
      eff = boot_mode_source_sel ? lw0[7:6] : default_boot_sel;
      chk("bov_sel", lw0[22:21], brownout_level_sel);
      chk("bov_mv", mv_tab[lw0[22:21]], brownout_mv);
      chk("bor_en", !lw0[20], brownout_reset_en);
      chk("debug_en", lw0[12], debug_port_enable);
      chk("quasi", lw0[10] & !ft, io_quasi_bidir);
      chk("boot_field", lw0[7:6], boot_source_sel);
      chk("from_loader", !eff[1], boot_from_loader);
      chk("in_app", !eff[0], in_app_programming);
      chk("ldr_base", eff[0] ? 32'h0 : 32'h00100000,
          loader_region_base);
      chk("app_base", 32'h0, application_region_base);
      chk("boot_sel_eff", prog_boot_select & eff[0],
          prog_boot_select_eff);
      chk("vector_map", vector_page_map_req & !eff[0],
          vector_page_map_en);
      chk("wdt", {lw0[31], lw0[4:3]}, watchdog_hw_enable);
      chk("mass_erase", lw0[5], mass_erase_enable);
      chk("locked", !lw0[1], flash_locked);
      chk("read_data", (!lw0[1] && !access_trusted) ? 32'hFFFFFFFF :
          flash_read_raw, flash_read_data);
      chk("data_en", !lw0[0], data_region_enable);
      chk("data_base", lw1[19:0], data_region_base);
      chk("release", 1'b1, cpu_release);
   endtask : check_out

   initial begin
      {reset_n, hsel, hwrite, boot_mode_source_sel, prog_boot_select} = 0;
      {vector_page_map_req, access_trusted, default_boot_sel} = 0;
      {htrans, haddr, hwdata, flash_read_raw, w0, w1} = 0;
      hsize = 3'h2;
      seed = 32'h01FE;
      fail_count = 0;
      samples_checked = 0;
      rd_pulses = 0;
      @(posedge clock);
      for (it = 0; it < 16; it++) begin
         lw0 = $random(seed);
         lw0[22:21] = it[1:0];
         lw0[7:6] = it[3:2];
         lw1 = $random(seed);
         lw1[10:0] = 11'h000;
         w0 <= lw0;
         w1 <= lw1;
         reset_n <= 1'b0;
         repeat (2) @(posedge clock);
         rd_pulses = 0;
         reset_n <= 1'b1;
         @(posedge clock);
         #1;
         chk("valid_early", 1'b0, config_valid);
         for (int n = 0; config_valid !== 1'b1; n++) begin
            @(posedge clock);
            if (n > 200) give_up("config_valid");
         end
         // Flash changing after the load must not reach the outputs
         w0 <= ~lw0;
         w1 <= ~lw1;
         r = $random(seed);
         boot_mode_source_sel <= r[0];
         default_boot_sel <= r[2:1];
         prog_boot_select <= r[3];
         vector_page_map_req <= r[4];
         access_trusted <= r[5];
         flash_read_raw <= $random(seed);
         repeat (WC + 4) @(posedge clock);
         #1;
         check_out(1'b0);
         chk("fetches", 2, rd_pulses);
         @(posedge clock);
         ahb(1'b1, 8'h00, ~lw0, q);
         ahb(1'b0, 8'h00, 32'h0, q);
         chk("word0", lw0 & 32'h807014FB, q);
         chk("hresp", 1'b0, hresp);
         ahb(1'b0, 8'h04, 32'h0, q);
         chk("word1", lw1 & 32'h000FFFFF, q);
         ahb(1'b0, 8'h1C, 32'h0, q);
         chk("unmapped", 32'h0, q);
         ahb(1'b1, 8'h0C, 32'h1, q);
         @(posedge clock);
         #1;
         check_out(1'b1);
         @(posedge clock);
         ahb(1'b0, 8'h08, 32'h0, q);
         chk("status", 32'h3, q);
         be = boot_mode_source_sel ? lw0[7:6] : default_boot_sel;
         ahb(1'b0, 8'h10, 32'h0, q);
         chk("decode", {18'h0, lw0[31], lw0[4:3], be, !be[1], !be[0],
             !lw0[1], !lw0[0], lw0[12], !lw0[20], 1'b0, lw0[22:21]},
             q);
         @(posedge clock);
         ahb(1'b1, 8'h0C, 32'h0, q);
      end
      stop_test;
   end
endmodule : tb_top
`default_nettype wire
